/* File: tcce_pkg.sv */
package tcce_pkg;
    // Register byte offsets
    localparam logic [7:0] TCCE_MODE_OFS = 8'h1C;
    localparam logic [7:0] TCCE_ENPOL_OFS = 8'h20;
    localparam logic [7:0] TCCE_MODE_CH12_OFS = 8'h18;
    localparam logic [7:0] TCCE_CTRL_OFS = 8'h44;
    localparam logic [15:0] TCCE_MODE_RST = 16'h0000;
    localparam logic [15:0] TCCE_ENPOL_RST = 16'h0000;
    // Mode register fields, high channel (4) and low channel (3)
    localparam int TCCE_HI_DIR = 8;
    localparam int TCCE_LO_DIR = 0;
    localparam int TCCE_HI_CLR = 15;
    localparam int TCCE_HI_CMP = 12;
    localparam int TCCE_HI_PRE = 11;
    localparam int TCCE_HI_FAST = 10;
    localparam int TCCE_LO_CLR = 7;
    localparam int TCCE_LO_CMP = 4;
    localparam int TCCE_LO_PRE = 3;
    localparam int TCCE_LO_FAST = 2;
    localparam int TCCE_HI_FILT = 12;
    localparam int TCCE_HI_PSC = 10;
    localparam int TCCE_LO_FILT = 4;
    localparam int TCCE_LO_PSC = 2;
    // Enable register: per channel group of four
    localparam int TCCE_GRP = 4;
    localparam int TCCE_EN = 0;
    localparam int TCCE_POL = 1;
    localparam int TCCE_CEN = 2;
    localparam int TCCE_CPOL = 3;
    localparam int TCCE_CH4_CEN_BIT = 14;
    // Control register fields
    localparam int TCCE_CTRL_MOE = 0;
    localparam int TCCE_CTRL_IDLE_OFFSTATE_SEL = 1;
    localparam int TCCE_CTRL_RUN_OFFSTATE_SEL = 2;
    localparam int TCCE_CTRL_LOCK = 4;
    localparam int TCCE_CTRL_IDLE = 8;
    localparam logic [15:0] TCCE_CTRL_RST = 16'h0000;
    localparam logic [15:0] TCCE_CTRL_MASK = 16'hFF37;
    localparam logic [1:0] TCCE_LOCK2 = 2'h2;

    typedef enum logic [1:0] {
        TCCE_DIR_OUT,
        TCCE_DIR_IN_A,
        TCCE_DIR_IN_B,
        TCCE_DIR_IN_TRG
    } tcce_dir_t;

    typedef enum logic [2:0] {
        TCCE_OC_FROZEN,
        TCCE_OC_SET,
        TCCE_OC_CLEAR,
        TCCE_OC_TOGGLE,
        TCCE_OC_FORCE_LO,
        TCCE_OC_FORCE_HI,
        TCCE_OC_PWM1,
        TCCE_OC_PWM2
    } tcce_oc_mode_t;

    typedef struct packed {
        logic [3:0] main_out;
        logic [3:0] main_oe;
        logic [3:0] comp_out;
        logic [3:0] comp_oe;
    } tcce_pins_t;

    typedef struct packed {
        logic [3:0] capture_en;
        logic [3:0] capture_edge_fall;
        logic [3:0] trig_in;
        logic [3:0] psc_reset;
    } tcce_cap_t;
endpackage

/* File: tcce_top.sv */
// Decided for this implementation: the Wishbone register port.
`timescale 1ns/1ns
// Function
// [R1] Channel-4 direction: 00 out, 01 input c, 10 input b, 11 trigger.
// [R2] Software picks trigger source only with an internal trigger selected.
// [R3] Channel-4 direction writable only while channel-4 enable is zero.
// [R4] Channel-3 direction: 00 out, 01 input b, 10 input c, 11 trigger.
// [R5] Channel-3 direction writable only while channel-3 enable is zero.
// [R6] Output-mode fields: ch4 at 15,14:12,11,10; ch3 at 7,6:4,3,2.
// [R7] Input-mode fields: filter/prescale ch4 15:12,11:10; ch3 7:4,3:2.
// [R8] Enable register: enable, polarity, comp enable, comp polarity per nibble.
// [R9] Complementary polarity zero is active high, one active low.
// [R10] Polarity bits locked at lock level 2 or 3; comp only for outputs.
// [R11] Comp enable clear: comp output inactive, level from off-state bits.
// [R12] Channel enable clear: main output inactive, level from off-state bits.
// [R13] Output polarity zero is active high, one active low.
// [R14] Input polarity zero rising, uninverted; one falling, inverted trigger.
// [R15] Input channel enable permits capture when set, blocks when clear.
// [R16] Capture prescaler reset while the channel enable bit is clear.
// [R17] Compare mode codes: frozen, set, clear, toggle, low, high, PWM1, PWM2.
// [R18] Software keeps idle and polarity bits clear with both outputs off.
// [R19] Channel-4 complementary enable bit reads zero and ignores writes.
module tcce_top
    import tcce_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Channel references from compare logic and timer inputs
    input wire logic [3:0] ref_in,
    input wire logic [3:0] timer_input,
    input wire logic internal_trigger_source,
    // Pins and capture controls
    output tcce_pkg::tcce_pins_t pins,
    output tcce_pkg::tcce_cap_t cap
);
    import tcce_pkg::*;

    logic [15:0] mode_ch12;
    logic [15:0] mode;
    logic [15:0] enpol;
    logic [15:0] ctrl;
    logic [15:0] wdata;
    logic [15:0] next_mode;
    logic [15:0] next_enpol;
    logic [15:0] next_mode_ch12;
    logic wr;
    logic locked;
    logic [1:0] dir [4];
    logic [15:0] next_ctrl;
    logic main_output_enable;
    logic idle_offstate_sel;
    logic run_offstate_sel;
    // Per-channel views of the enable register, direction and input source
    logic [3:0] ch_en;
    logic [3:0] ch_cen;
    logic [3:0] ch_pol;
    logic [3:0] ch_cpol;
    logic [3:0] ch_out;
    logic [3:0] ch_src;
    tcce_pins_t next_pins;
    tcce_cap_t next_cap;

    assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
    assign wdata = {wb_sel_i[1] ? wb_dat_i[15:8] : 8'h00, wb_sel_i[0] ? wb_dat_i[7:0] : 8'h00};
    assign locked = ctrl[TCCE_CTRL_LOCK +: 2] >= TCCE_LOCK2;
    assign dir[0] = mode_ch12[1:0];
    assign dir[1] = mode_ch12[9:8];
    assign dir[2] = mode[TCCE_LO_DIR +: 2];
    assign dir[3] = mode[TCCE_HI_DIR +: 2];
    assign main_output_enable = ctrl[TCCE_CTRL_MOE];
    assign idle_offstate_sel = ctrl[TCCE_CTRL_IDLE_OFFSTATE_SEL];
    assign run_offstate_sel = ctrl[TCCE_CTRL_RUN_OFFSTATE_SEL];

    // Byte-lane merge, then direction locks
    always_comb begin
        next_mode = mode;
        if (wb_sel_i[0]) begin
            next_mode[7:0] = wdata[7:0];
        end
        if (wb_sel_i[1]) begin
            next_mode[15:8] = wdata[15:8];
        end
        // [R3] ch4 direction guard
        if (enpol[3*TCCE_GRP + TCCE_EN]) begin
            next_mode[TCCE_HI_DIR +: 2] = mode[TCCE_HI_DIR +: 2];
        end
        // [R5] ch3 direction guard
        if (enpol[2*TCCE_GRP + TCCE_EN]) begin
            next_mode[TCCE_LO_DIR +: 2] = mode[TCCE_LO_DIR +: 2];
        end
    end

    always_comb begin
        next_mode_ch12 = mode_ch12;
        if (wb_sel_i[0]) begin
            next_mode_ch12[7:0] = wdata[7:0];
        end
        if (wb_sel_i[1]) begin
            next_mode_ch12[15:8] = wdata[15:8];
        end
        if (enpol[TCCE_EN]) begin
            next_mode_ch12[1:0] = mode_ch12[1:0];
        end
        if (enpol[TCCE_GRP + TCCE_EN]) begin
            next_mode_ch12[9:8] = mode_ch12[9:8];
        end
    end

    always_comb begin
        next_enpol = enpol;
        if (wb_sel_i[0]) begin
            next_enpol[7:0] = wdata[7:0];
        end
        if (wb_sel_i[1]) begin
            next_enpol[15:8] = wdata[15:8];
        end
        for (int c = 0; c < 4; c++) begin
            // [R10] polarity lock
            if (locked) begin
                next_enpol[c*TCCE_GRP + TCCE_POL] = enpol[c*TCCE_GRP + TCCE_POL];
                if (dir[c] == TCCE_DIR_OUT) begin
                    next_enpol[c*TCCE_GRP + TCCE_CPOL] = enpol[c*TCCE_GRP + TCCE_CPOL];
                end
            end
        end
        // [R19] reserved bit
        next_enpol[TCCE_CH4_CEN_BIT] = 1'b0;
    end

    // Control word; lock level only rises until reset
    always_comb begin
        next_ctrl = ctrl;
        if (wb_sel_i[0]) begin
            next_ctrl[7:0] = wdata[7:0] & TCCE_CTRL_MASK[7:0];
        end
        if (wb_sel_i[1]) begin
            next_ctrl[15:8] = wdata[15:8] & TCCE_CTRL_MASK[15:8];
        end
        // A lower lock value is ignored so software cannot unlock
        next_ctrl[TCCE_CTRL_LOCK +: 2] = ctrl[TCCE_CTRL_LOCK +: 2];
        if (wb_sel_i[0] && (wdata[TCCE_CTRL_LOCK +: 2] > ctrl[TCCE_CTRL_LOCK +: 2])) begin
            next_ctrl[TCCE_CTRL_LOCK +: 2] = wdata[TCCE_CTRL_LOCK +: 2];
        end
    end

    // Register writes
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            mode <= TCCE_MODE_RST;
            mode_ch12 <= TCCE_MODE_RST;
            enpol <= TCCE_ENPOL_RST;
            ctrl <= TCCE_CTRL_RST;
        end else if (wr) begin
            case (wb_adr_i)
                // [R6] [R7] field layout is the stored word
                TCCE_MODE_OFS: mode <= next_mode;
                TCCE_MODE_CH12_OFS: mode_ch12 <= next_mode_ch12;
                // [R8] enable register
                TCCE_ENPOL_OFS: enpol <= next_enpol;
                // Lock raise-only merge is done in next_ctrl
                TCCE_CTRL_OFS: ctrl <= next_ctrl;
                default: ;
            endcase
        end
    end

    // Bus answer: one registered ack per request, the cycle after the strobe
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
            case (wb_adr_i)
                TCCE_MODE_OFS: wb_dat_o <= {16'h0000, mode};
                TCCE_MODE_CH12_OFS: wb_dat_o <= {16'h0000, mode_ch12};
                TCCE_ENPOL_OFS: wb_dat_o <= {16'h0000, enpol};
                TCCE_CTRL_OFS: wb_dat_o <= {16'h0000, ctrl};
                default: wb_dat_o <= 32'h0000_0000;
            endcase
        end
    end

    // Per-channel enable group and direction decode
    for (genvar c = 0; c < 4; c++) begin : g_chan
        assign ch_en[c] = enpol[c*TCCE_GRP + TCCE_EN];
        assign ch_pol[c] = enpol[c*TCCE_GRP + TCCE_POL];
        assign ch_cen[c] = enpol[c*TCCE_GRP + TCCE_CEN];
        assign ch_cpol[c] = enpol[c*TCCE_GRP + TCCE_CPOL];
        assign ch_out[c] = dir[c] == TCCE_DIR_OUT;
    end

    // [R1] [R4] input source routing
    always_comb begin
        ch_src = 4'h0;
        for (int c = 0; c < 4; c++) begin
            case (dir[c])
                TCCE_DIR_IN_A: begin
                    ch_src[c] = timer_input[c];
                end
                TCCE_DIR_IN_B: begin
                    // Neighbour pairing: channel 3 takes input 4 and 4 takes 3
                    ch_src[c] = timer_input[c ^ 1];
                end
                TCCE_DIR_IN_TRG: begin
                    // Only meaningful with an internal trigger selected upstream
                    ch_src[c] = internal_trigger_source;
                end
                default: begin
                    ch_src[c] = 1'b0;
                end
            endcase
        end
    end

    // Pin levels; no dead-time, both outputs move in the same cycle
    always_comb begin
        next_pins = '0;
        for (int c = 0; c < 4; c++) begin
            if (!ch_out[c]) begin
                // Input channel never drives its pins
                next_pins.main_oe[c] = 1'b0;
                next_pins.main_out[c] = 1'b0;
                next_pins.comp_oe[c] = 1'b0;
                next_pins.comp_out[c] = 1'b0;
            end else if (main_output_enable) begin
                // [R12] [R13] main output, off-state only with run off-state
                next_pins.main_oe[c] = ch_en[c] || (run_offstate_sel && ch_cen[c]);
                if (ch_en[c]) begin
                    next_pins.main_out[c] = ref_in[c] ^ ch_pol[c];
                end else begin
                    next_pins.main_out[c] = run_offstate_sel && ch_pol[c];
                end
                // [R11] [R9] comp output, reference inverted only beside a live main
                next_pins.comp_oe[c] = ch_cen[c] || (run_offstate_sel && ch_en[c]);
                if (ch_cen[c]) begin
                    next_pins.comp_out[c] = ref_in[c] ^ ch_en[c] ^ ch_cpol[c];
                end else begin
                    next_pins.comp_out[c] = run_offstate_sel && ch_cpol[c];
                end
            end else begin
                // Main enable off: idle levels, driven only with idle off-state
                next_pins.main_oe[c] = idle_offstate_sel && (ch_en[c] || ch_cen[c]);
                next_pins.main_out[c] = ctrl[TCCE_CTRL_IDLE + 2*c];
                next_pins.comp_oe[c] = idle_offstate_sel && (ch_en[c] || ch_cen[c]);
                next_pins.comp_out[c] = ctrl[TCCE_CTRL_IDLE + 2*c + 1];
            end
            // [R19] channel 4 has no complementary pin
            if (c == 3) begin
                next_pins.comp_oe[c] = 1'b0;
                next_pins.comp_out[c] = 1'b0;
            end
        end
    end

    // Capture controls
    always_comb begin
        next_cap = '0;
        for (int c = 0; c < 4; c++) begin
            // [R15] capture gate
            next_cap.capture_en[c] = !ch_out[c] && ch_en[c];
            // [R14] edge select and trigger polarity
            next_cap.capture_edge_fall[c] = ch_pol[c];
            next_cap.trig_in[c] = !ch_out[c] && (ch_src[c] ^ ch_pol[c]);
            // [R16] prescaler held clear while disabled
            next_cap.psc_reset[c] = !ch_en[c];
        end
    end

    // Registered pins, one cycle after the register change
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pins <= '0;
        end else begin
            pins <= next_pins;
        end
    end

    // Registered capture controls
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cap <= '0;
        end else begin
            cap <= next_cap;
        end
    end
endmodule // tcce_top

/* File: tcce_pin_model.sv */
`timescale 1ns/1ns
module tcce_pin_model (
    // Step request and pin levels
    input wire logic clk,
    input wire logic upd,
    output logic [8:0] lvl
);
    // New random pin levels one edge after a step request
    always @(posedge clk) begin
        lvl <= upd ? 9'($urandom) : lvl;
    end
    initial lvl = 9'h000;
endmodule // tcce_pin_model

/* File: tcce_checker.sv */
`timescale 1ns/1ns
module tcce_checker
    import tcce_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // Pins and capture
    input wire tcce_pkg::tcce_pins_t pins,
    input wire tcce_pkg::tcce_cap_t cap
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held");
    AST_ACK_REQ: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("no ack");
    AST_ACK_CAUSE: assert property (wb_ack_o |-> $past(wb_cyc_i) && $past(wb_stb_i))
        else $error("stray ack");
    AST_DAT_HIGH: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
        else $error("upper data set");
    AST_RSV_RD:
        assert property (wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) == TCCE_ENPOL_OFS |-> !wb_dat_o[14])
        else $error("bit 14 read set");
    AST_CH4_COMP_OFF: assert property (!pins.comp_oe[3])
        else $error("ch4 comp driven");
    AST_PSC_EXCL: assert property ((cap.capture_en & cap.psc_reset) == 4'h0)
        else $error("capture during prescaler reset");
    AST_IN_NO_DRIVE: assert property ((cap.capture_en & (pins.main_oe | pins.comp_oe)) == 4'h0)
        else $error("input channel drives");
    AST_RST_QUIET: assert property ($past(sys_rst) |-> pins == '0 && cap == '0 && !wb_ack_o)
        else $error("outputs after reset");
endmodule // tcce_checker

/* File: tcce_top_bench.sv */
`timescale 1ns/1ns
module tcce_top_bench;
    import tcce_pkg::*;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic cyc = 1'b0;
    logic we = 1'b0;
    logic upd = 1'b0;
    logic ack;
    logic [7:0] adr = 8'h00;
    logic [31:0] dat = 32'h0, q, rd;
    logic [8:0] lvl;
    tcce_pins_t pins;
    tcce_cap_t cap;
    int miscompares = 0, checks = 0, cycles = 0, mode = 0, enp = 0, lk = 0, v, p, e, k;
    always #5 clk = ~clk;
    tcce_top DUT (.clk(clk), .sys_rst(sys_rst), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'h3), .wb_dat_i(dat), .wb_dat_o(q), .wb_ack_o(ack), .ref_in(lvl[3:0]),
        .timer_input(lvl[7:4]), .internal_trigger_source(lvl[8]), .pins(pins), .cap(cap));
    tcce_pin_model PM (.clk(clk), .upd(upd), .lvl(lvl));
    task automatic finish_test();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input int d);
        d = d & 32'hFFFF;
        @(posedge clk);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        @(posedge clk);
        while (ack !== 1'b1) @(posedge clk);
        rd = q;
        cyc <= 1'b0;
        if (!w) return;
        // Direction held while channel on
        k = (enp[12] ? 32'h300 : 0) | (enp[8] ? 3 : 0);
        if (a == TCCE_MODE_OFS) mode = d & ~k | mode & k;
        k = lk > 1 ? 32'h22AA | (mode[1:0] ? 0 : 32'h800) | (mode[9:8] ? 0 : 32'h8000) : 0;
        if (a == TCCE_ENPOL_OFS) enp = (d & ~k | enp & k) & 32'hBFFF;
        if (a == TCCE_CTRL_OFS && d[5:4] > lk) lk = d[5:4];
    endtask
    task automatic step();
        @(posedge clk);
        upd <= 1'b1;
        @(posedge clk);
        upd <= 1'b0;
        repeat (3) @(posedge clk);
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            finish_test();
        end
    end
    initial begin
        void'($urandom(1));
        repeat (20) @(posedge clk);
        sys_rst <= 1'b0;
        wb(1, 8'h3C, $urandom);
        wb(0, 8'h3C, 0);
        chk(rd, 0);
        wb(0, TCCE_ENPOL_OFS, 0);
        chk(rd, enp);
        for (int i = 0; i < 8; i++) begin
            wb(1, TCCE_MODE_OFS, $urandom & 32'h8F8F | i << 12 | i << 4);
            wb(0, TCCE_MODE_OFS, 0);
            chk(rd, mode);
        end
        wb(1, TCCE_CTRL_OFS, 1);
        wb(1, TCCE_MODE_OFS, 0);
        for (int c = 0; c < 7; c++) begin
            v = c / 2;
            p = $urandom & 1;
            wb(1, TCCE_ENPOL_OFS, (c % 2 ? 4 | p << 3 : 1 | p << 1) << v * 4);
            step();
            chk({pins.main_out[v], pins.main_oe[v], pins.comp_out[v], pins.comp_oe[v]},
                c % 2 ? {lvl[v] ^ p[0], 1'b1} : {lvl[v] ^ p[0], 3'b100});
        end
        wb(1, TCCE_ENPOL_OFS, 32'h5);
        step();
        chk({pins.main_out[0], pins.main_oe[0], pins.comp_out[0], pins.comp_oe[0]}, {lvl[0], 1'b1, !lvl[0], 1'b1});
        wb(1, TCCE_CTRL_OFS, 32'h5);
        wb(1, TCCE_ENPOL_OFS, 32'h1);
        step();
        chk({pins.main_out[0], pins.main_oe[0], pins.comp_out[0], pins.comp_oe[0]}, {lvl[0], 3'b101});
        wb(1, TCCE_CTRL_OFS, 32'h302);
        step();
        chk({pins.main_out[0], pins.main_oe[0], pins.comp_out[0], pins.comp_oe[0]}, 4'hF);
        wb(1, TCCE_CTRL_OFS, 1);
        wb(1, TCCE_ENPOL_OFS, 32'hFFFF);
        wb(1, TCCE_MODE_OFS, 32'h0303);
        wb(0, TCCE_MODE_OFS, 0);
        chk(rd, mode);
        wb(0, TCCE_ENPOL_OFS, 0);
        chk(rd, enp);
        for (int i = 2; i < 8; i++) begin
            v = i / 2;
            // trigger source picked as if an internal trigger were selected
            wb(1, TCCE_ENPOL_OFS, 0);
            wb(1, TCCE_MODE_OFS, v << 8 | v);
            e = $urandom & 32'h3300;
            wb(1, TCCE_ENPOL_OFS, e);
            step();
            p = v == 3 ? {2{lvl[8]}} : v == 1 ? lvl[7:6] : {lvl[6], lvl[7]};
            for (int c = 2; c < 4; c++) begin
                chk({cap.capture_en[c], cap.capture_edge_fall[c], cap.trig_in[c], cap.psc_reset[c]},
                    {e[c * 4], e[c * 4 + 1], p[c - 2] ^ e[c * 4 + 1], !e[c * 4]});
            end
        end
        wb(1, TCCE_CTRL_OFS, 32'h21);
        wb(1, TCCE_ENPOL_OFS, 32'hAAAA);
        wb(0, TCCE_ENPOL_OFS, 0);
        chk(rd, enp);
        sys_rst <= 1'b1;
        mode = 0;
        enp = 0;
        lk = 0;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        wb(0, TCCE_MODE_OFS, 0);
        chk(rd, mode);
        wb(0, TCCE_ENPOL_OFS, 0);
        chk(rd, enp);
        finish_test();
    end
endmodule // tcce_top_bench
bind tcce_top tcce_checker CHK (.clk(clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pins(pins), .cap(cap));
